/* rtl/evc_velocity_counter.sv */
`timescale 1ns/10ps
// Contract
// - Each result holds the encoder change count and the interval length in 100 MHz timebase ticks.
// - The change count is signed, its sign giving the direction of motion.
// - In quadrature decoding A leading B counts up and B leading A counts down.
// - In two-pulse decoding an A pulse counts up and a B pulse counts down.
// - Decoding is selectable as two-pulse, single, double or quad edge quadrature.
// - The A and B source terminals are selected independently.
// - A nonzero maximum count period that passes without a count change forces a zero result.
// - A zero maximum count period disables the timeout; measuring continues through each result and runs until overflow or stop.
// - The interval is set by the divisor, the measurement time, or both.
// - After arming, measurement starts at the first active encoder edge.
// - Until the first interval completes or times out the result and result_ready read zero.
// - Each counter input is routable from any of the eight digital input terminals.
// - Eight independent counters share the eight digital input terminals.
// - Default A comes from input n and default B from input (n+4) mod 8.
// - Default edge-counting routing is source n, reset n+4, direction 7-n, pause 3-n, all mod 8.
module evc_velocity_counter
#(
  parameter int COUNTER_INDEX = 0
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [evc_pkg::NUM_INPUTS-1:0] digital_input_terminal,
  input wire logic arm,
  input wire logic stop,
  input wire logic use_default_route,
  input wire evc_pkg::evc_cfg_type cfg,
  output evc_pkg::evc_result_type result,
  output logic result_ready,
  output logic result_strobe,
  output logic running,
  output logic overflow,
  output logic timeout
);
  // Default routing, kept for every measurement that shares this terminal set
  localparam logic [2:0] DEF_A = 3'(COUNTER_INDEX);
  localparam logic [2:0] DEF_B = 3'((COUNTER_INDEX + 4) % 8);
  localparam logic [2:0] DEF_Z = 3'(7 - COUNTER_INDEX);
  localparam logic [2:0] DEF_PAUSE = 3'((3 - COUNTER_INDEX + 8) % 8);

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h1,
    ST_WAIT_EDGE = 3'h2,
    ST_MEASURE = 3'h4
  } evc_state_type;

  evc_state_type state;
  evc_state_type next_state;
  logic [evc_pkg::TICK_W-1:0] tick_cnt;
  logic signed [evc_pkg::CHG_W-1:0] chg_cnt;
  logic [31:0] step_cnt;
  logic [31:0] idle_cnt;
  logic step;
  logic step_down;

  wire [2:0] a_src = use_default_route ? DEF_A : cfg.a_sel;
  wire [2:0] b_src = use_default_route ? DEF_B : cfg.b_sel;
  wire enc_a = digital_input_terminal[a_src];
  wire enc_b = digital_input_terminal[b_src];

  evc_quad_decoder u_decoder
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .enc_a(enc_a),
    .enc_b(enc_b),
    .decode(cfg.decode),
    .step(step),
    .step_down(step_down)
  );

  localparam evc_pkg::evc_result_type ZERO_RESULT = '0;

  // State decodes
  wire idle = state == ST_IDLE;
  wire waiting = state == ST_WAIT_EDGE;
  wire measuring = state == ST_MEASURE;
  wire take_arm = idle && arm;

  // Interval method
  wire div_on = cfg.divisor != 32'h0000_0000;
  wire time_on = cfg.meas_time != 32'h0000_0000;
  wire method_set = div_on || time_on;
  wire period_on = cfg.max_period != 32'h0000_0000;

  // Running sums
  wire [31:0] next_steps = step ? step_cnt + 32'h0000_0001 : step_cnt;
  wire [evc_pkg::TICK_W-1:0] next_ticks = tick_cnt + 32'h0000_0001;
  wire signed [evc_pkg::CHG_W-1:0] chg_up = chg_cnt + 32'sh0000_0001;
  wire signed [evc_pkg::CHG_W-1:0] chg_down = chg_cnt - 32'sh0000_0001;
  wire signed [evc_pkg::CHG_W-1:0] chg_step = step_down ? chg_down : chg_up;
  wire signed [evc_pkg::CHG_W-1:0] next_chg = step ? chg_step : chg_cnt;
  wire [31:0] next_idle = step ? 32'h0000_0000 : idle_cnt + 32'h0000_0001;

  // Both set: the interval needs the divisor count and the minimum time
  wire div_done = !div_on || (next_steps >= cfg.divisor);
  wire time_done = !time_on || (next_ticks >= cfg.meas_time);
  // Intervals close only on a change; the ticks span whole count periods except after a timeout, which restarts them mid-period
  wire interval_end = measuring && method_set && step && div_done && time_done;
  // The idle counter watches changes only; a stopped encoder ends the interval with a zero result
  wire period_expired = measuring && period_on && !step && (idle_cnt >= cfg.max_period);
  wire tick_wrap = measuring && (tick_cnt == '1);
  wire start_edge = waiting && step;
  wire load_result = interval_end || period_expired;
  // Counters restart at each interval end so intervals abut with no lost changes
  wire restart = !measuring || load_result;

  // Next register values
  wire [evc_pkg::TICK_W-1:0] next_tick_cnt = restart ? '0 : next_ticks;
  wire signed [evc_pkg::CHG_W-1:0] next_chg_cnt = restart ? '0 : next_chg;
  wire [31:0] next_step_cnt = restart ? 32'h0000_0000 : next_steps;
  wire [31:0] next_idle_cnt = restart ? 32'h0000_0000 : next_idle;
  wire evc_pkg::evc_result_type measured = {next_ticks, next_chg};
  wire evc_pkg::evc_result_type next_result =
    take_arm ? ZERO_RESULT :
    interval_end ? measured :
    period_expired ? ZERO_RESULT : result;
  wire next_ready = !take_arm && (result_ready || load_result);
  wire next_timeout = !take_arm && !interval_end && (timeout || period_expired);
  wire next_overflow = !take_arm && (overflow || tick_wrap);
  wire next_running = next_state == ST_MEASURE;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (take_arm)
          next_state = ST_WAIT_EDGE;
      end
      ST_WAIT_EDGE:
      begin
        if (stop)
          next_state = ST_IDLE;
        else if (start_edge)
          next_state = ST_MEASURE;
      end
      ST_MEASURE:
      begin
        if (stop || tick_wrap)
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tick_cnt <= '0;
    end
    else if (clk_en)
    begin
      tick_cnt <= next_tick_cnt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      chg_cnt <= '0;
    end
    else if (clk_en)
    begin
      chg_cnt <= next_chg_cnt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      step_cnt <= '0;
    end
    else if (clk_en)
    begin
      step_cnt <= next_step_cnt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      idle_cnt <= '0;
    end
    else if (clk_en)
    begin
      idle_cnt <= next_idle_cnt;
    end
  end

  // Ticks and changes share one register, so a read never mixes two intervals
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      result <= ZERO_RESULT;
    end
    else if (clk_en)
    begin
      result <= next_result;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      result_ready <= 1'b0;
    end
    else if (clk_en)
    begin
      result_ready <= next_ready;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      result_strobe <= 1'b0;
    end
    else if (clk_en)
    begin
      result_strobe <= load_result;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      running <= 1'b0;
    end
    else if (clk_en)
    begin
      running <= next_running;
    end
  end

  // Sticky until the next arm; a wrap also ends the measurement
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      overflow <= 1'b0;
    end
    else if (clk_en)
    begin
      overflow <= next_overflow;
    end
  end

  // Tells a zero from a timeout apart from a genuine zero-change result
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      timeout <= 1'b0;
    end
    else if (clk_en)
    begin
      timeout <= next_timeout;
    end
  end
endmodule

/* pkg/evc_pkg.sv */
package evc_pkg;
  localparam int NUM_INPUTS = 8;
  localparam int NUM_COUNTERS = 8;
  localparam int SEL_W = 3;
  localparam int TICK_W = 32;
  localparam int CHG_W = 32;
  localparam int SYNC_STAGES = 2;
  // Timebase
  localparam int TIMEBASE_MHZ = 100;
  // Decoding types
  localparam logic [1:0] DEC_TWO_PULSE = 2'h0;
  localparam logic [1:0] DEC_SINGLE_EDGE = 2'h1;
  localparam logic [1:0] DEC_DOUBLE_EDGE = 2'h2;
  localparam logic [1:0] DEC_QUAD_EDGE = 2'h3;
  // Reset values
  localparam logic [1:0] RST_DECODE = DEC_QUAD_EDGE;
  localparam logic [31:0] RST_DIVISOR = 32'h0000_0001;
  localparam logic [31:0] RST_MEAS_TIME = 32'h0000_0000;
  localparam logic [31:0] RST_MAX_PERIOD = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] decode;
    logic [SEL_W-1:0] a_sel;
    logic [SEL_W-1:0] b_sel;
    logic [31:0] divisor;
    logic [31:0] meas_time;
    logic [31:0] max_period;
  } evc_cfg_type;

  typedef struct packed {
    logic [TICK_W-1:0] ticks;
    logic signed [CHG_W-1:0] changes;
  } evc_result_type;
endpackage

/* rtl/evc_quad_decoder.sv */
`timescale 1ns/10ps
module evc_quad_decoder
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [1:0] decode,
  output logic step,
  output logic step_down
);
  logic prev_a;
  logic prev_b;
  wire a_rise = enc_a & ~prev_a;
  wire a_fall = ~enc_a & prev_a;
  wire b_rise = enc_b & ~prev_b;
  wire b_fall = ~enc_b & prev_b;
  wire a_edge = a_rise | a_fall;
  wire b_edge = b_rise | b_fall;
  // A leads B: on an A edge, new A differs from B
  wire a_dir_down = ~(enc_a ^ enc_b);
  wire b_dir_down = enc_a ^ enc_b;
  logic next_step;
  logic next_down;

  always_comb
  begin
    next_step = 1'b0;
    next_down = 1'b0;
    unique case (decode)
      evc_pkg::DEC_TWO_PULSE:
      begin
        next_step = a_rise | b_rise;
        next_down = b_rise & ~a_rise;
        if (a_rise & b_rise)
          next_step = 1'b0;
      end
      evc_pkg::DEC_SINGLE_EDGE:
      begin
        // Up on A rise with B low, down on A fall with B low
        next_step = (a_rise | a_fall) & ~enc_b;
        next_down = a_fall;
      end
      evc_pkg::DEC_DOUBLE_EDGE:
      begin
        next_step = a_edge;
        next_down = a_dir_down;
      end
      evc_pkg::DEC_QUAD_EDGE:
      begin
        // Simultaneous A and B edges are an illegal jump and are dropped
        next_step = a_edge ^ b_edge;
        next_down = a_edge ? a_dir_down : b_dir_down;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      step <= 1'b0;
      step_down <= 1'b0;
    end
    else if (clk_en)
    begin
      prev_a <= enc_a;
      prev_b <= enc_b;
      step <= next_step;
      step_down <= next_down;
    end
  end
endmodule

/* verification/evc_props.sv */
`timescale 1ns/10ps
module evc_props
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [evc_pkg::NUM_INPUTS-1:0] digital_input_terminal,
  input wire logic arm,
  input wire logic stop,
  input wire logic use_default_route,
  input wire evc_pkg::evc_cfg_type cfg,
  input wire evc_pkg::evc_result_type result,
  input wire logic result_ready,
  input wire logic result_strobe,
  input wire logic running,
  input wire logic overflow,
  input wire logic timeout
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_rdy; result_strobe |-> result_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("strobe without ready");
  property p_zero; !result_ready |-> result == '0; endproperty
  a_zero: assert property (p_zero) else $error("result before ready");
  property p_hold; $changed(result) |-> result_strobe || $past(arm); endproperty
  a_hold: assert property (p_hold) else $error("result moved alone");
  property p_tmo; timeout |-> result == '0 && result_ready; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout not zero");
  property p_notmo; cfg.max_period == '0 |-> !$rose(timeout); endproperty
  a_notmo: assert property (p_notmo) else $error("timeout while off");
  property p_arm; arm && clk_en && !running |=> result == '0 && !overflow; endproperty
  a_arm: assert property (p_arm) else $error("arm kept old result");
  // A decoded change needs two cycles to reach running, so three quiet samples rule it out
  property p_wait; ($stable(digital_input_terminal) && !running) [*3] |=> !running; endproperty
  a_wait: assert property (p_wait) else $error("ran without edge");
  property p_end;
    result_strobe && !timeout |-> $past(digital_input_terminal, 2) != $past(digital_input_terminal, 3);
  endproperty
  a_end: assert property (p_end) else $error("result without change");
  c_tmo: cover property ($rose(timeout));
  c_neg: cover property (result_strobe && result.changes < 0);
  c_run: cover property ($rose(running));
endmodule

bind evc_velocity_counter evc_props u_evc_props
(
  .sys_clk, .rst, .clk_en, .digital_input_terminal, .arm, .stop, .use_default_route, .cfg, .result,
  .result_ready, .result_strobe, .running, .overflow, .timeout
);

/* verification/evc_enc_model.sv */
`timescale 1ns/10ps
module evc_enc_model
(
  input wire logic sys_clk,
  input wire logic [2:0] a_pos,
  input wire logic [2:0] b_pos,
  input wire logic noise,
  output logic [7:0] term
);
  logic a = 1'b0;
  logic b = 1'b0;
  logic [7:0] bg = 8'h00;
  // Idle terminals flip every cycle on request, so a wrong route shows up
  always @(negedge sys_clk)
    if (noise)
      bg <= ~bg;
  always_comb
  begin
    term = bg;
    term[a_pos] = a;
    term[b_pos] = b;
  end
  // Caller sits on a falling edge; the levels hold g cycles
  task set_ab(input logic [1:0] v, input int g);
    {a, b} = v;
    repeat (g) @(negedge sys_clk);
  endtask
endmodule

/* verification/evc_velocity_counter_tb.sv */
`timescale 1ns/10ps
module evc_velocity_counter_tb;
  logic sys_clk;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic arm = 1'b0;
  logic stop = 1'b0;
  logic dflt = 1'b1;
  logic noise = 1'b0;
  logic [2:0] a_pos = 3'h0;
  logic [2:0] b_pos = 3'h4;
  logic [7:0] term;
  evc_pkg::evc_cfg_type cfg = '0;
  evc_pkg::evc_result_type result;
  evc_pkg::evc_result_type last = '0;
  logic result_ready;
  logic result_strobe;
  logic running;
  logic overflow;
  logic timeout;
  logic [31:0] t2;
  int err_total = 0;
  int compares = 0;
  evc_velocity_counter u_evc_velocity_counter
  (
    .sys_clk, .rst, .clk_en, .digital_input_terminal(term), .arm, .stop, .use_default_route(dflt), .cfg,
    .result, .result_ready, .result_strobe, .running, .overflow, .timeout
  );
  evc_enc_model u_evc_enc_model (.sys_clk, .a_pos, .b_pos, .noise, .term);
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk)
    if (result_strobe === 1'b1)
      last <= result;
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // A wrong a_sel under default routing proves the default wins
  task start(input logic [1:0] d, input logic [31:0] dv, input logic [31:0] mt, input logic [31:0] mp);
    @(negedge sys_clk);
    stop = 1'b1;
    cfg = '{d, a_pos + 3'(dflt), b_pos, dv, mt, mp};
    last = '0;
    @(negedge sys_clk);
    stop = 1'b0;
    arm = 1'b1;
    @(negedge sys_clk);
    arm = 1'b0;
    chk(result.ticks | result.changes, 32'h0, "armed result");
  endtask
  // Forward steps 10,11,01,00; reverse swaps A and B
  task quad(input logic fwd, input int n, input int g);
    logic [1:0] v;
    for (int i = 0; i < 4 * n; i++)
    begin
      v = 2'(8'h1e >> (2 * (i % 4)));
      u_evc_enc_model.set_ab(fwd ? v : {v[0], v[1]}, g);
    end
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk(result_ready, 1'b0, "ready");
    for (int d = 1; d < 4; d++)
      for (int f = 0; f < 2; f++)
      begin
        start(2'(d), 32'h1 << (d - 1), 32'h0, 32'h0);
        quad(f[0], 2, 3);
        repeat (4) @(negedge sys_clk);
        chk(last.changes, f ? 32'h1 << (d - 1) : -(32'h1 << (d - 1)), "quad");
      end
    start(2'h0, 32'h1, 32'h0, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      u_evc_enc_model.set_ab(i == 2 ? 2'h1 : 2'h2, 3);
      u_evc_enc_model.set_ab(2'h0, 3);
      if (i > 0)
        chk(last.changes, i == 1 ? 32'h1 : 32'hffff_ffff, "pulse");
    end
    start(2'h3, 32'h1, 32'h0, 32'h0);
    u_evc_enc_model.set_ab(2'h2, 5);
    u_evc_enc_model.set_ab(2'h3, 5);
    u_evc_enc_model.set_ab(2'h1, 40);
    t2 = last.ticks;
    u_evc_enc_model.set_ab(2'h0, 5);
    chk(last.ticks - t2, 32'h23, "ticks");
    chk(timeout, 1'b0, "timeout off");
    chk(overflow, 1'b0, "overflow");
    start(2'h3, 32'h1, 32'h0, 32'h14);
    u_evc_enc_model.set_ab(2'h2, 3);
    u_evc_enc_model.set_ab(2'h3, 40);
    chk({timeout, result_ready}, 2'h3, "timeout");
    chk(result.ticks | result.changes, 32'h0, "timeout result");
    start(2'h3, 32'h0, 32'h1e, 32'h0);
    quad(1'b1, 2, 8);
    chk(last.changes, 32'h4, "timed");
    dflt = 1'b0;
    noise = 1'b1;
    a_pos = 3'h2;
    b_pos = 3'h5;
    start(2'h3, 32'h2, 32'h0, 32'h0);
    quad(1'b0, 1, 4);
    chk(last.changes, 32'hffff_fffe, "routed");
    clk_en = 1'b0;
    quad(1'b0, 1, 4);
    clk_en = 1'b1;
    @(negedge sys_clk);
    chk(last.changes, 32'hffff_fffe, "frozen");
    chk(running, 1'b1, "frozen run");
    stop_test;
  end
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    stop_test;
  end
endmodule
